// ### logic/rxo_pkg.sv
// Shared types and constants for the receive output and fault flag block
package rxo_pkg;

  // Status word layout; bit positions follow the field order below
  typedef struct packed {
    logic       rsvd7;
    logic       rsvd6;
    logic       cmi_err;
    logic       sig_absent;
    logic       rx_unlock;
    logic       unused2;
    logic       tx_unlock;
    logic       fifo_fault;
  } rxo_stat_t;

  // Enables after reset: transmit unlock and code violation only
  localparam rxo_stat_t EN_RST      = 8'h22;
  // Sources that feed each interrupt output
  localparam rxo_stat_t TX_SRC_MASK = 8'h03;
  localparam rxo_stat_t RX_SRC_MASK = 8'h38;
  localparam rxo_stat_t STAT_RST    = 8'h00;

  // Bit slots within one nibble, counted in recovered line clock edges
  localparam logic [1:0] SLOT_FALL  = 2'h1;
  localparam logic [1:0] SLOT_CAPT  = 2'h3;
  localparam logic [1:0] SLOT_RST   = 2'h0;

  // Line rate over nibble clock rate: 155.52 MHz / 38.88 MHz
  localparam int unsigned LINE_PER_NIB = 4;
  // Frequency window in ppm beyond which lock counts as lost
  localparam int unsigned LOCK_PPM     = 1000;
  localparam int unsigned PPM_SCALE    = 1000000;

endpackage

// ### logic/rxo_core.sv
// Receive nibble output, loss flags and fault interrupt outputs
`timescale 1ns/1ps

module rxo_core
  import rxo_pkg::*;
#(
  parameter int unsigned REF_HALF  = 2,
  parameter int unsigned LOCK_WIN  = 4000,
  parameter int unsigned EXP_EDGES = 1000
)
(
  // Clock and reset
  input  logic      ref_clk,
  input  logic      sys_rst,
  input  logic      por_n,
  // Recovered line from the clock recovery
  input  logic      line_clk_in,
  input  logic      line_data_in,
  // Analog and transmit side event levels
  input  logic      sig_absent_in,
  input  logic      cmi_violation_in,
  input  logic      tx_unlock_in,
  input  logic      fifo_fault_in,
  input  logic      fifo_recenter_n,
  // Mode and control
  input  logic      cmi_mode,
  input  logic      irq_enable_load,
  input  rxo_stat_t irq_enable_in,
  input  logic      status_read,
  // Outputs to the framer
  output logic [3:0] rx_nibble_data,
  output logic      rx_nibble_clock,
  output logic      signal_absent_flag,
  output logic      lock_lost_flag,
  output logic      tx_fault_irq_n,
  output logic      rx_fault_irq_n,
  output rxo_stat_t status_value,
  output rxo_stat_t irq_enable
);

  localparam int unsigned TOL_EDGES = (EXP_EDGES * LOCK_PPM) / PPM_SCALE;
  localparam int unsigned WIN_W = $clog2(LOCK_WIN + 1);
  localparam int unsigned DIV_W = $clog2(REF_HALF + 1);

  // Refuse settings the counters cannot serve
  if (REF_HALF < 1 || EXP_EDGES < 1 || 2 * EXP_EDGES > LOCK_WIN)
    $error("rxo_core: bad REF_HALF, LOCK_WIN or EXP_EDGES");

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; first stage is read only by the second
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] pins_w;

  assign pins_w = {por_n, line_clk_in, line_data_in, sig_absent_in,
                   cmi_violation_in, tx_unlock_in, fifo_fault_in, fifo_recenter_n};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 8'h01;
      sync2_r <= 8'h01;
    end
    else
    begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  logic por_s, lclk_s, ldat_s, absent_s, cmiv_s, txul_s, ffault_s, recn_s;
  assign {por_s, lclk_s, ldat_s, absent_s, cmiv_s, txul_s, ffault_s, recn_s} = sync2_r;

  // Power-on reset, active low, folded into the core reset
  // active high core reset
  logic core_rst;
  assign core_rst = sys_rst | ~por_s;

  // Edge detectors on settled copies
  logic lclk_d_r, recn_d_r;
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      lclk_d_r <= 1'b0;
      recn_d_r <= 1'b1;
    end
    else
    begin
      lclk_d_r <= lclk_s;
      recn_d_r <= recn_s;
    end
  end

  logic line_tick, recn_rise;
  assign line_tick = lclk_s & ~lclk_d_r;
  assign recn_rise = recn_s & ~recn_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Nibble assembly: shift in at the bottom so the first bit ends on top
  logic [2:0] shift_r;
  logic [1:0] slot_r;
  logic [3:0] hold_r;
  logic [3:0] data_r;
  logic       clk_r;
  logic [DIV_W-1:0] div_r;
  logic       ref_tick;

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      shift_r <= 3'h0;
      slot_r  <= SLOT_RST;
      hold_r  <= 4'h0;
    end
    else if (line_tick)
    begin
      shift_r <= {shift_r[1:0], ldat_s};
      slot_r  <= slot_r + 2'h1;
      if (slot_r == SLOT_CAPT)
        hold_r <= {shift_r, ldat_s};
    end
  end

  // Reference divider; a one-cycle enable every REF_HALF cycles
  assign ref_tick = (div_r == DIV_W'(REF_HALF - 1));
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      div_r <= '0;
    else
      div_r <= ref_tick ? '0 : div_r + DIV_W'(1);
  end

  // Clock source select: the recovered slots, or the reference when absent
  logic src_fall, src_rise;
  assign src_fall = signal_absent_flag ? (ref_tick & clk_r)
                                       : (line_tick & (slot_r == SLOT_FALL));
  assign src_rise = signal_absent_flag ? (ref_tick & ~clk_r)
                                       : (line_tick & (slot_r == SLOT_CAPT));

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      clk_r  <= 1'b0;
      data_r <= 4'h0;
    end
    else if (src_fall)
    begin
      clk_r  <= 1'b0;
      data_r <= hold_r;
    end
    else if (src_rise)
      clk_r <= 1'b1;
  end

  assign rx_nibble_data  = data_r;
  assign rx_nibble_clock = clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frequency check: count line edges per reference window
  logic [WIN_W-1:0] win_r;
  logic [WIN_W-1:0] edges_r;
  logic             lol_r;
  logic             win_end;
  logic             off_rate;

  assign win_end  = (win_r == WIN_W'(LOCK_WIN - 1));
  assign off_rate = (edges_r > WIN_W'(EXP_EDGES + TOL_EDGES)) ||
                    (edges_r < WIN_W'(EXP_EDGES - TOL_EDGES));

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      win_r   <= '0;
      edges_r <= '0;
      lol_r   <= 1'b0;
    end
    else if (win_end)
    begin
      win_r   <= '0;
      edges_r <= WIN_W'(line_tick); // End cycle's edge opens the next window, none is lost
      lol_r   <= off_rate;
    end
    else
    begin
      win_r   <= win_r + WIN_W'(1);
      edges_r <= edges_r + WIN_W'(line_tick);
    end
  end

  assign lock_lost_flag = lol_r;

  // Absence detector is only trusted on the coded electrical line
  // CMI mode only
  logic absent_r;
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      absent_r <= 1'b0;
    else
      absent_r <= absent_s & cmi_mode;
  end
  assign signal_absent_flag = absent_r;

  ////////////////////////////////////////////////////////////////////////////
  // Events, sticky status and enables
  rxo_stat_t ev_w, stat_r, stat_nxt, en_r;

  assign ev_w = '{rsvd7: 1'b0, rsvd6: 1'b0, cmi_err: cmiv_s, sig_absent: absent_r,
                  rx_unlock: lol_r, unused2: 1'b0, tx_unlock: txul_s,
                  fifo_fault: ffault_s};

  // Set wins over the read clear; recenter low holds the FIFO bit clear
  // cleared on read
  always_comb
  begin
    stat_nxt = (status_read ? STAT_RST : stat_r) | ev_w;
    if (!recn_s)
      stat_nxt.fifo_fault = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      stat_r <= STAT_RST;
      en_r   <= EN_RST;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (irq_enable_load)
        en_r <= irq_enable_in;
    end
  end

  assign status_value = stat_r;
  assign irq_enable   = en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt latches; cause of the transmit one kept for the FIFO clear
  logic tx_pend_r, rx_pend_r, tx_other_r;
  logic tx_ev, rx_ev, tx_fifo_ev;

  assign tx_ev      = |(ev_w & en_r & TX_SRC_MASK);
  assign rx_ev      = |(ev_w & en_r & RX_SRC_MASK);
  assign tx_fifo_ev = ev_w.fifo_fault & en_r.fifo_fault;

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      tx_pend_r  <= 1'b0;
      tx_other_r <= 1'b0;
    end
    else if (tx_ev)
    begin
      tx_pend_r  <= 1'b1;
      tx_other_r <= (tx_other_r & ~status_read) | (tx_ev & ~tx_fifo_ev)
                    | ev_w.tx_unlock & en_r.tx_unlock;
    end
    else if (status_read || (recn_rise && !tx_other_r))
    begin
      tx_pend_r  <= 1'b0;
      tx_other_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      rx_pend_r <= 1'b0;
    else if (rx_ev)
      rx_pend_r <= 1'b1;
    else if (status_read)
      rx_pend_r <= 1'b0;
  end

  assign tx_fault_irq_n = ~tx_pend_r;
  assign rx_fault_irq_n = ~rx_pend_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (core_rst);

  nibble_on_fall_a: assert property ($changed(rx_nibble_data) |-> $fell(rx_nibble_clock))
    else $error("nibble data changed away from a clock fall");
  absent_ref_clock_a: assert property (signal_absent_flag && ref_tick
                                       |=> $changed(rx_nibble_clock))
    else $error("nibble clock not following reference while absent");
  absent_gated_a: assert property (!cmi_mode |=> !signal_absent_flag)
    else $error("absent flag raised outside CMI mode");
  tx_irq_set_a: assert property (tx_ev |=> !tx_fault_irq_n ##1
                                 (!tx_fault_irq_n || $past(status_read) || $past(recn_rise)))
    else $error("transmit interrupt not asserted on enabled event");
  rx_irq_set_a: assert property (rx_ev |=> !rx_fault_irq_n)
    else $error("receive interrupt not asserted on enabled event");
  read_release_a: assert property (status_read && !tx_ev && !rx_ev
                                   |=> tx_fault_irq_n && rx_fault_irq_n)
    else $error("status read did not release interrupts");
  recenter_clear_a: assert property (recn_rise && !tx_other_r && !tx_ev |=> tx_fault_irq_n)
    else $error("recenter did not clear FIFO interrupt");
  irq_held_a: assert property (!tx_fault_irq_n && !tx_ev && !status_read && !recn_rise
                               |=> !tx_fault_irq_n)
    else $error("transmit interrupt dropped without clearing action");
  unlock_status_a: assert property ($rose(lock_lost_flag) |=> status_value.rx_unlock)
    else $error("unlock status bit not set");
  reset_enable_a: assert property ($fell(core_rst) && !irq_enable_load
                                   |-> irq_enable == EN_RST)
    else $error("enables after reset wrong");

  nibble_cov_c:   cover property (src_fall && !signal_absent_flag);
  absent_cov_c:   cover property ($rose(signal_absent_flag));
  recenter_cov_c: cover property (recn_rise && tx_pend_r && !tx_other_r);
  unlock_cov_c:   cover property ($rose(lock_lost_flag));

endmodule

// ### testbench/rxo_framer_model.sv
// Framer-side model that latches each nibble from the block
`timescale 1ns/1ps

module rxo_framer_model
(
  // Nibble stream from the block
  input  logic [3:0] rx_nibble_data,
  input  logic       rx_nibble_clock,
  // What the framer saw
  output logic [3:0] last_word,
  output int         word_cnt,
  output int         bad_cnt
);
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    word_cnt = 0;
    bad_cnt  = 0;
  end

  // latch on rise
  // Data moves on the fall, so the rise is the safe sampling point
  always @(posedge rx_nibble_clock)
  begin
    last_word <= rx_nibble_data;
    word_cnt  <= word_cnt + 1;
  end

  // data change check
  // A change while the clock is high could tear the framer's latch
  // Look a moment later, so a change that rides the fall is not miscounted
  always @(rx_nibble_data)
  begin
    #1;
    if (rx_nibble_clock === 1'b1)
      bad_cnt <= bad_cnt + 1;
  end
endmodule

// ### testbench/rx_output_and_fault_flags_tb.sv
// Self-checking bench for the receive output and fault flag block
`timescale 1ns/1ps

module rx_output_and_fault_flags_tb
  import rxo_pkg::*;
;
  logic ref_clk, sys_rst, por_n, line_clk_in, line_data_in;
  logic sig_absent_in, cmi_violation_in, tx_unlock_in, fifo_fault_in;
  logic fifo_recenter_n, cmi_mode, irq_enable_load, status_read;
  rxo_stat_t irq_enable_in, status_value, irq_enable;
  logic [3:0] rx_nibble_data, last_word;
  logic rx_nibble_clock, signal_absent_flag, lock_lost_flag;
  logic tx_fault_irq_n, rx_fault_irq_n;
  int word_cnt, bad_cnt, error_cnt, checks, tgl;

  ////////////////////////////////////////////////////////////////////
  // Short lock window keeps the run brief
  rxo_core #(.REF_HALF(2), .LOCK_WIN(400), .EXP_EDGES(100)) i_dut (.*);
  rxo_framer_model i_framer (.*);

  // steady reference, no drift
  // The bench reference runs at a fixed nominal period, well inside its tolerance
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Let edges land, then look at settled values
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Line clock at an eighth of ref_clk, well under the sync limit
  task send_bit(input logic b);
    @(posedge ref_clk);
    line_data_in <= b;
    line_clk_in  <= 1'b0;
    repeat (4) @(posedge ref_clk);
    line_clk_in  <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  task rd_status;
    @(posedge ref_clk);
    status_read <= 1'b1;
    @(posedge ref_clk);
    status_read <= 1'b0;
    settle(1);
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("status", status_value, STAT_RST);
    chk("enables", irq_enable, 8'h22);
    chk("tx irq", tx_fault_irq_n, 1'h1);
    chk("rx irq", rx_fault_irq_n, 1'h1);
  endtask

  // Three nibbles; the middle one is on the pins afterwards
  task t_nibble;
    logic [11:0] w;
    w = 12'h4b7;
    for (int i = 11; i >= 0; i--)
      send_bit(w[i]);
    settle(6);
    chk("nibble", rx_nibble_data, 4'hb);
    chk("framer word", last_word, 4'hb);
    chk("framer words", word_cnt, 8'h03);
    chk("tear count", bad_cnt, 0);
  endtask

  task t_tx;
    @(posedge ref_clk);
    tx_unlock_in <= 1'b1;
    settle(4);
    chk("tx irq", tx_fault_irq_n, 1'h0);
    chk("tx unlock bit", status_value.tx_unlock, 1'h1);
    @(posedge ref_clk);
    tx_unlock_in <= 1'b0;
    settle(4);
    chk("tx irq held", tx_fault_irq_n, 1'h0);
    rd_status();
    chk("tx irq read", tx_fault_irq_n, 1'h1);
  endtask

  task t_rx;
    @(posedge ref_clk);
    cmi_violation_in <= 1'b1;
    settle(4);
    chk("rx irq", rx_fault_irq_n, 1'h0);
    chk("tx irq quiet", tx_fault_irq_n, 1'h1);
    @(posedge ref_clk);
    cmi_violation_in <= 1'b0;
    settle(4);
    chk("rx irq held", rx_fault_irq_n, 1'h0);
    rd_status();
    chk("rx irq read", rx_fault_irq_n, 1'h1);
  endtask

  task t_fifo;
    @(posedge ref_clk);
    fifo_fault_in <= 1'b1;
    settle(4);
    chk("tx irq masked", tx_fault_irq_n, 1'h1);
    chk("fifo bit", status_value.fifo_fault, 1'h1);
    @(posedge ref_clk);
    fifo_fault_in   <= 1'b0;
    irq_enable_load <= 1'b1;
    irq_enable_in   <= 8'h23;
    @(posedge ref_clk);
    irq_enable_load <= 1'b0;
    rd_status();
    chk("enables", irq_enable, 8'h23);
    @(posedge ref_clk);
    fifo_fault_in <= 1'b1;
    @(posedge ref_clk);
    fifo_fault_in <= 1'b0;
    settle(4);
    chk("tx irq fifo", tx_fault_irq_n, 1'h0);
    @(posedge ref_clk);
    fifo_recenter_n <= 1'b0;
    settle(4);
    chk("fifo bit cleared", status_value.fifo_fault, 1'h0);
    chk("tx irq before rise", tx_fault_irq_n, 1'h0);
    @(posedge ref_clk);
    fifo_recenter_n <= 1'b1;
    settle(4);
    chk("tx irq recenter", tx_fault_irq_n, 1'h1);
  endtask

  task t_los;
    logic prev;
    @(posedge ref_clk);
    sig_absent_in <= 1'b1;
    settle(4);
    chk("absent nrz", signal_absent_flag, 1'h0);
    @(posedge ref_clk);
    cmi_mode <= 1'b1;
    settle(4);
    chk("absent cmi", signal_absent_flag, 1'h1);
    tgl  = 0;
    prev = rx_nibble_clock;
    repeat (40)
    begin
      settle(1);
      if (rx_nibble_clock !== prev)
        tgl++;
      prev = rx_nibble_clock;
    end
    chk("fallback clock", (tgl >= 19 && tgl <= 21), 1'h1);
    chk("tear count los", bad_cnt, 0);
    @(posedge ref_clk);
    sig_absent_in <= 1'b0;
    cmi_mode      <= 1'b0;
  endtask

  // No line edges at all is far outside the window
  task t_lock;
    settle(900);
    chk("lock lost", lock_lost_flag, 1'h1);
    chk("unlock bit", status_value.rx_unlock, 1'h1);
  endtask

  // Line clock of period four cycles: exactly the expected edges per window
  task t_lock_ok;
    repeat (650)
    begin
      repeat (2) @(posedge ref_clk);
      line_clk_in <= ~line_clk_in;
    end
    settle(0);
    chk("lock held", lock_lost_flag, 1'h0);
  endtask

  // Power-on reset pin in mid-run restores the reset state
  task t_por;
    @(posedge ref_clk);
    por_n <= 1'b0;
    settle(4);
    chk("por enables", irq_enable, EN_RST);
    chk("por status", status_value, STAT_RST);
    chk("por lock", lock_lost_flag, 1'h0);
    chk("por nibble clock", rx_nibble_clock, 1'h0);
    @(posedge ref_clk);
    por_n <= 1'b1;
    settle(4);
    chk("por release enables", irq_enable, EN_RST);
    chk("por release status", status_value, STAT_RST);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    checks    = 0;
    {sys_rst, por_n, fifo_recenter_n} = 3'h7;
    {line_clk_in, line_data_in, sig_absent_in, cmi_violation_in} = 4'h0;
    {tx_unlock_in, fifo_fault_in, cmi_mode} = 3'h0;
    {irq_enable_load, status_read} = 2'h0;
    irq_enable_in = 8'h00;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle(4);
    t_reset();
    t_nibble();
    t_tx();
    t_rx();
    t_fifo();
    t_los();
    t_lock_ok();
    t_lock();
    t_por();
    tally_and_finish();
  end

  // Watchdog well beyond the few thousand cycles the tests take
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
